// >>> drcs_map.svh
// Constants for the result status block: bit positions, codes, limits.
// ----------------------------------------------------------------------
// Summary of operation
// - Precomp-disable bit stored, no effect, read at bit 2 in third mode.
// - Density select high after hardware reset, kept over software resets.
// - Result phase presents status bytes of just-completed command on reads.
// - Byte zero bits 7:6 give termination class 00/01/10/11.
// - Byte zero bit 5 set after seek, relative seek or recalibrate.
// - Byte zero bit 4 flags 80 steps without track zero or outward overstep.
// - Byte zero holds head in bit 2 and drive in bits 1:0.
// - Unused status bits always read zero.
// - Byte one bit 7 flags sector beyond track end or missing count.
// - Byte one bit 5 flags CRC error in ID or data field.
// - Byte one bit 4 flags late service, overrun or underrun.
// - Byte one bit 2 flags sector missed, bad ID read or wrong sequence.
// - Byte one bit 1 flags write protect during write or format.
// - Byte one bit 0 flags missing ID mark after two index pulses or data mark.
// - Byte two bit 6 flags unexpected deleted or normal data mark.
// - Byte two bit 5 flags CRC error in data field.
// - Byte two bit 4 flags ID track differing from internal track.
// - Byte two bit 1 flags differing ID track equal to ff.
// - Byte two bit 0 flags no data or deleted data mark.
// ----------------------------------------------------------------------
`ifndef DRCS_MAP_SVH
`define DRCS_MAP_SVH

// ----------------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------------
`define DRCS_S0_CLS_HI 7
`define DRCS_S0_CLS_LO 6
`define DRCS_S0_SEEK 5
`define DRCS_S0_FAULT 4
`define DRCS_S0_HEAD 2
`define DRCS_S0_DRV_HI 1
`define DRCS_S0_DRV_LO 0
`define DRCS_S1_END_CYL 7
`define DRCS_S1_CRC 5
`define DRCS_S1_LATE 4
`define DRCS_S1_MISS 2
`define DRCS_S1_WPROT 1
`define DRCS_S1_AMARK 0
`define DRCS_S2_CTRL 6
`define DRCS_S2_CRC 5
`define DRCS_S2_TRK 4
`define DRCS_S2_BAD 1
`define DRCS_S2_DMARK 0
`define DRCS_RATE_PREC 2
`define DRCS_CCR_PREC 2

// ----------------------------------------------------------------------
// Error flag vector indexes
// ----------------------------------------------------------------------
`define DRCS_F_END_CYL 0
`define DRCS_F_CRC_ANY 1
`define DRCS_F_OVERRUN 2
`define DRCS_F_SECT_MISS 3
`define DRCS_F_WR_BLOCK 4
`define DRCS_F_AM_MISS 5
`define DRCS_F_CTRL_MARK 6
`define DRCS_F_CRC_DATA 7
`define DRCS_F_TRK_MISM 8
`define DRCS_F_BAD_TRK 9
`define DRCS_F_DM_MISS 10
`define DRCS_NFLAGS 11

// ----------------------------------------------------------------------
// Codes, limits and reset values
// ----------------------------------------------------------------------
`define DRCS_END_NORM 2'h0
`define DRCS_END_ABN 2'h1
`define DRCS_END_BAD_CMD 2'h2
`define DRCS_END_POLL 2'h3
`define DRCS_RECAL_STEPS 7'h50
`define DRCS_INDEX_LIMIT 2'h2
`define DRCS_BAD_TRACK 8'hff
`define DRCS_LEN_FULL 2'h3
`define DRCS_LEN_ONE 2'h1
`define DRCS_BYTE0 2'h0
`define DRCS_BYTE1 2'h1
`define DRCS_BYTE2 2'h2
`define DRCS_DENS_RST 1'h1
`define DRCS_PREC_RST 1'h0

`endif

// >>> drcs_pkg.sv
// Types shared by the result status block.
package drcs_pkg;
	typedef enum logic [3:0] {
		DRCS_CMD_READ,
		DRCS_CMD_READ_DEL,
		DRCS_CMD_WRITE,
		DRCS_CMD_WRITE_DEL,
		DRCS_CMD_FORMAT,
		DRCS_CMD_READ_ID,
		DRCS_CMD_READ_TRACK,
		DRCS_CMD_SEEK,
		DRCS_CMD_REL_SEEK,
		DRCS_CMD_RECAL,
		DRCS_CMD_SENSE_INT,
		DRCS_CMD_OTHER
	} drcs_cmd_t;

	typedef enum logic [1:0] {
		DRCS_IDLE,
		DRCS_EXEC,
		DRCS_RESULT
	} drcs_state_t;
endpackage

// >>> drcs_step_watch.sv
// Recalibrate step watcher: counts step pulses, flags missing track zero.
`timescale 1ns/1ps
`default_nettype none
`include "drcs_map.svh"

module drcs_step_watch (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	input wire logic active_i,
	input wire logic step_i,
	input wire logic track_zero_i,
	output logic fault_o
);
	logic [6:0] step_cnt_r;

	// Saturates so a long runaway recalibrate cannot wrap and hide the fault
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			step_cnt_r <= 7'h00;
		end else if (clear_i) begin
			step_cnt_r <= 7'h00;
		end else if (active_i && step_i && step_cnt_r != `DRCS_RECAL_STEPS) begin
			step_cnt_r <= step_cnt_r + 7'h01;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fault_o <= 1'b0;
		end else if (clear_i) begin
			fault_o <= 1'b0;
		end else if (active_i && step_cnt_r == `DRCS_RECAL_STEPS &&
				!track_zero_i) begin
			fault_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> drcs_result_status.sv
// Result status assembly and result-phase read-out for the disk controller.
`timescale 1ns/1ps
`default_nettype none
`include "drcs_map.svh"

module drcs_result_status (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic soft_reset_i,
	input wire logic ccr_wr_i,
	input wire logic [7:0] ccr_wdata_i,
	input wire logic legacy_mode_i,
	input wire logic density_wr_i,
	input wire logic density_val_i,
	input wire logic cmd_start_i,
	input wire drcs_pkg::drcs_cmd_t cmd_kind_i,
	input wire logic head_i,
	input wire logic [1:0] drive_number_i,
	input wire logic cmd_end_i,
	input wire logic invalid_cmd_i,
	input wire logic poll_abort_i,
	input wire logic sector_beyond_i,
	input wire logic terminal_count_missing_i,
	input wire logic id_crc_err_i,
	input wire logic data_crc_err_i,
	input wire logic service_late_i,
	input wire logic sector_not_found_i,
	input wire logic id_unreadable_i,
	input wire logic sequence_wrong_i,
	input wire logic write_protect_i,
	input wire logic index_pulse_in_i,
	input wire logic id_mark_found_i,
	input wire logic data_mark_absent_i,
	input wire logic deleted_mark_seen_i,
	input wire logic normal_mark_seen_i,
	input wire logic id_track_valid_i,
	input wire logic [7:0] id_track_i,
	input wire logic [7:0] internal_track_i,
	input wire logic step_pulse_i,
	input wire logic track_zero_in_i,
	input wire logic outward_past_zero_i,
	input wire logic result_rd_i,
	output logic [7:0] result_data_o,
	output logic request_for_master_o,
	output logic transfer_direction_o,
	output logic precomp_disable_o,
	output logic [7:0] rate_status_o,
	output logic density_select_out_o
);
	import drcs_pkg::*;

	drcs_state_t state_r;
	drcs_cmd_t kind_r;
	logic head_r;
	logic [1:0] drive_r;
	logic [`DRCS_NFLAGS-1:0] err_r;
	logic [`DRCS_NFLAGS-1:0] err_set;
	logic [1:0] index_cnt_r;
	logic am_timeout;
	logic seek_pend_r;
	logic seek_fault_r;
	logic recal_fault;
	logic relseek_fault_r;
	logic [7:0] sb0_r;
	logic [7:0] sb1_r;
	logic [7:0] sb2_r;
	logic [7:0] sb0_nxt;
	logic [1:0] res_idx_r;
	logic [1:0] res_len_r;
	logic [1:0] res_len_nxt;
	logic executing;
	logic ending;
	logic is_seek_kind;

	// ------------------------------------------------------------------
	// Command decoding helpers
	// ------------------------------------------------------------------
	function automatic logic is_write_cmd(input drcs_cmd_t k);
		return k == DRCS_CMD_WRITE || k == DRCS_CMD_WRITE_DEL ||
			k == DRCS_CMD_FORMAT;
	endfunction

	function automatic logic is_data_cmd(input drcs_cmd_t k);
		return k == DRCS_CMD_READ || k == DRCS_CMD_READ_DEL ||
			k == DRCS_CMD_READ_ID || k == DRCS_CMD_READ_TRACK ||
			is_write_cmd(k);
	endfunction

	function automatic logic [7:0] pick_byte(input logic [1:0] idx,
			input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b2);
		unique case (idx)
			`DRCS_BYTE0: return b0;
			`DRCS_BYTE1: return b1;
			default: return b2;
		endcase
	endfunction

	assign executing = state_r == DRCS_EXEC;
	assign ending = executing && cmd_end_i;
	assign is_seek_kind = kind_r == DRCS_CMD_SEEK ||
		kind_r == DRCS_CMD_REL_SEEK || kind_r == DRCS_CMD_RECAL;

	// ------------------------------------------------------------------
	// Configuration bits that survive software reset
	// ------------------------------------------------------------------
	// Stored only; nothing in the controller acts on it
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			precomp_disable_o <= `DRCS_PREC_RST;
		end else if (ccr_wr_i) begin
			precomp_disable_o <= ccr_wdata_i[`DRCS_CCR_PREC];
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rate_status_o <= 8'h00;
		end else begin
			rate_status_o <= 8'h00;
			if (legacy_mode_i) begin
				rate_status_o[`DRCS_RATE_PREC] <= precomp_disable_o;
			end
		end
	end

	// Software reset deliberately absent here
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			density_select_out_o <= `DRCS_DENS_RST;
		end else if (density_wr_i) begin
			density_select_out_o <= density_val_i;
		end
	end

	// ------------------------------------------------------------------
	// Command context
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			kind_r <= DRCS_CMD_OTHER;
			head_r <= 1'b0;
			drive_r <= 2'h0;
		end else if (cmd_start_i && state_r == DRCS_IDLE) begin
			kind_r <= cmd_kind_i;
			head_r <= head_i;
			drive_r <= drive_number_i;
		end
	end

	// ------------------------------------------------------------------
	// Error event capture
	// ------------------------------------------------------------------
	assign am_timeout = executing && is_data_cmd(kind_r) &&
		index_pulse_in_i && index_cnt_r == `DRCS_INDEX_LIMIT - 2'h1;

	always_comb begin
		err_set = '0;
		if (executing) begin
			err_set[`DRCS_F_END_CYL] = sector_beyond_i ||
				terminal_count_missing_i;
			err_set[`DRCS_F_CRC_ANY] = id_crc_err_i || data_crc_err_i;
			err_set[`DRCS_F_OVERRUN] = service_late_i;
			err_set[`DRCS_F_SECT_MISS] = ((kind_r == DRCS_CMD_READ ||
				kind_r == DRCS_CMD_READ_DEL) && sector_not_found_i) ||
				(kind_r == DRCS_CMD_READ_ID && id_unreadable_i) ||
				(kind_r == DRCS_CMD_READ_TRACK && sequence_wrong_i);
			err_set[`DRCS_F_WR_BLOCK] = is_write_cmd(kind_r) &&
				write_protect_i;
			err_set[`DRCS_F_AM_MISS] = am_timeout ||
				data_mark_absent_i;
			err_set[`DRCS_F_CTRL_MARK] = (kind_r == DRCS_CMD_READ &&
				deleted_mark_seen_i) || (kind_r == DRCS_CMD_READ_DEL &&
				normal_mark_seen_i);
			err_set[`DRCS_F_CRC_DATA] = data_crc_err_i;
			err_set[`DRCS_F_TRK_MISM] = id_track_valid_i &&
				id_track_i != internal_track_i;
			err_set[`DRCS_F_BAD_TRK] = id_track_valid_i &&
				id_track_i != internal_track_i &&
				id_track_i == `DRCS_BAD_TRACK;
			err_set[`DRCS_F_DM_MISS] = data_mark_absent_i;
		end
	end

	// Flags clear at command start; events in that idle cycle are not captured
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			err_r <= '0;
		end else if (soft_reset_i) begin
			err_r <= '0;
		end else if (cmd_start_i && state_r == DRCS_IDLE) begin
			err_r <= err_set;
		end else begin
			err_r <= err_r | err_set;
		end
	end

	// Index pulses seen while hunting an ID mark
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			index_cnt_r <= 2'h0;
		end else if (soft_reset_i || !executing || id_mark_found_i) begin
			index_cnt_r <= 2'h0;
		end else if (index_pulse_in_i && index_cnt_r != `DRCS_INDEX_LIMIT) begin
			index_cnt_r <= index_cnt_r + 2'h1;
		end
	end

	// ------------------------------------------------------------------
	// Seek completion and equipment check
	// ------------------------------------------------------------------
	drcs_step_watch u_step_watch (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(soft_reset_i || (cmd_start_i && state_r == DRCS_IDLE)),
		.active_i(executing && kind_r == DRCS_CMD_RECAL),
		.step_i(step_pulse_i),
		.track_zero_i(track_zero_in_i),
		.fault_o(recal_fault)
	);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			relseek_fault_r <= 1'b0;
		end else if (soft_reset_i || (cmd_start_i && state_r == DRCS_IDLE)) begin
			relseek_fault_r <= 1'b0;
		end else if (executing && kind_r == DRCS_CMD_REL_SEEK &&
				outward_past_zero_i) begin
			relseek_fault_r <= 1'b1;
		end
	end

	// Pending seek end waits for the sense-interrupt command to report it
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seek_pend_r <= 1'b0;
			seek_fault_r <= 1'b0;
		end else if (soft_reset_i) begin
			seek_pend_r <= 1'b0;
			seek_fault_r <= 1'b0;
		end else if (ending && is_seek_kind) begin
			seek_pend_r <= 1'b1;
			seek_fault_r <= recal_fault || relseek_fault_r ||
				(kind_r == DRCS_CMD_REL_SEEK && outward_past_zero_i);
		end else if (ending && kind_r == DRCS_CMD_SENSE_INT) begin
			seek_pend_r <= 1'b0;
			seek_fault_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Status byte zero assembly
	// ------------------------------------------------------------------
	always_comb begin
		logic abnormal;
		abnormal = |(err_r | err_set);
		sb0_nxt = 8'h00;
		sb0_nxt[`DRCS_S0_HEAD] = head_r;
		sb0_nxt[`DRCS_S0_DRV_HI:`DRCS_S0_DRV_LO] = drive_r;
		res_len_nxt = `DRCS_LEN_FULL;
		if (invalid_cmd_i) begin
			sb0_nxt[`DRCS_S0_CLS_HI:`DRCS_S0_CLS_LO] = `DRCS_END_BAD_CMD;
			res_len_nxt = `DRCS_LEN_ONE;
		end else if (poll_abort_i) begin
			sb0_nxt[`DRCS_S0_CLS_HI:`DRCS_S0_CLS_LO] = `DRCS_END_POLL;
		end else if (kind_r == DRCS_CMD_SENSE_INT) begin
			sb0_nxt[`DRCS_S0_SEEK] = seek_pend_r;
			sb0_nxt[`DRCS_S0_FAULT] = seek_fault_r;
			sb0_nxt[`DRCS_S0_CLS_HI:`DRCS_S0_CLS_LO] = seek_fault_r ?
				`DRCS_END_ABN : `DRCS_END_NORM;
			res_len_nxt = `DRCS_LEN_ONE;
		end else begin
			sb0_nxt[`DRCS_S0_CLS_HI:`DRCS_S0_CLS_LO] = abnormal ?
				`DRCS_END_ABN : `DRCS_END_NORM;
		end
	end

	// ------------------------------------------------------------------
	// Latched result bytes
	// ------------------------------------------------------------------
	// Taken once at termination so mid-read events cannot tear a byte
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sb0_r <= 8'h00;
			sb1_r <= 8'h00;
			sb2_r <= 8'h00;
			res_len_r <= `DRCS_LEN_ONE;
		end else if (ending && !is_seek_kind) begin
			sb0_r <= sb0_nxt;
			sb1_r <= {(err_r[`DRCS_F_END_CYL] | err_set[`DRCS_F_END_CYL]),
				1'b0,
				(err_r[`DRCS_F_CRC_ANY] | err_set[`DRCS_F_CRC_ANY]),
				(err_r[`DRCS_F_OVERRUN] | err_set[`DRCS_F_OVERRUN]),
				1'b0,
				(err_r[`DRCS_F_SECT_MISS] | err_set[`DRCS_F_SECT_MISS]),
				(err_r[`DRCS_F_WR_BLOCK] | err_set[`DRCS_F_WR_BLOCK]),
				(err_r[`DRCS_F_AM_MISS] | err_set[`DRCS_F_AM_MISS])};
			sb2_r <= {1'b0,
				(err_r[`DRCS_F_CTRL_MARK] | err_set[`DRCS_F_CTRL_MARK]),
				(err_r[`DRCS_F_CRC_DATA] | err_set[`DRCS_F_CRC_DATA]),
				(err_r[`DRCS_F_TRK_MISM] | err_set[`DRCS_F_TRK_MISM]),
				2'b00,
				(err_r[`DRCS_F_BAD_TRK] | err_set[`DRCS_F_BAD_TRK]),
				(err_r[`DRCS_F_DM_MISS] | err_set[`DRCS_F_DM_MISS])};
			res_len_r <= res_len_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Phase control and data port read-out
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= DRCS_IDLE;
		end else if (soft_reset_i) begin
			state_r <= DRCS_IDLE;
		end else begin
			unique case (state_r)
				DRCS_IDLE: begin
					if (cmd_start_i) begin
						state_r <= DRCS_EXEC;
					end
				end
				DRCS_EXEC: begin
					if (cmd_end_i) begin
						state_r <= is_seek_kind ? DRCS_IDLE : DRCS_RESULT;
					end
				end
				DRCS_RESULT: begin
					if (result_rd_i && res_idx_r == res_len_r - 2'h1) begin
						state_r <= DRCS_IDLE;
					end
				end
			endcase
		end
	end

	// Reads outside the result phase are ignored by this block
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			res_idx_r <= `DRCS_BYTE0;
			result_data_o <= 8'h00;
		end else if (soft_reset_i) begin
			res_idx_r <= `DRCS_BYTE0;
			result_data_o <= 8'h00;
		end else if (ending && !is_seek_kind) begin
			res_idx_r <= `DRCS_BYTE0;
			result_data_o <= sb0_nxt;
		end else if (state_r == DRCS_RESULT && result_rd_i &&
				res_idx_r != res_len_r - 2'h1) begin
			// Final read leaves the last byte standing on the port
			res_idx_r <= res_idx_r + 2'h1;
			result_data_o <= pick_byte(res_idx_r + 2'h1, sb0_r, sb1_r,
				sb2_r);
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			request_for_master_o <= 1'b0;
			transfer_direction_o <= 1'b0;
		end else if (soft_reset_i) begin
			request_for_master_o <= 1'b0;
			transfer_direction_o <= 1'b0;
		end else if (ending && !is_seek_kind) begin
			request_for_master_o <= 1'b1;
			transfer_direction_o <= 1'b1;
		end else if (state_r == DRCS_RESULT && result_rd_i &&
				res_idx_r == res_len_r - 2'h1) begin
			request_for_master_o <= 1'b0;
			transfer_direction_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_prec_keep;
		!ccr_wr_i |=> $stable(precomp_disable_o);
	endproperty
	a_prec_keep: assert property (p_prec_keep)
		else $error("precomp bit changed without a write");

	property p_dens_keep;
		soft_reset_i && !density_wr_i |=> $stable(density_select_out_o);
	endproperty
	a_dens_keep: assert property (p_dens_keep)
		else $error("density select moved on software reset");

	property p_first_byte;
		ending && !is_seek_kind && !soft_reset_i |=>
			result_data_o == sb0_r && request_for_master_o &&
			transfer_direction_o;
	endproperty
	a_first_byte: assert property (p_first_byte)
		else $error("result phase did not open with byte zero");

	property p_invalid_code;
		ending && invalid_cmd_i && !soft_reset_i |=>
			sb0_r[`DRCS_S0_CLS_HI:`DRCS_S0_CLS_LO] == `DRCS_END_BAD_CMD &&
			res_len_r == `DRCS_LEN_ONE;
	endproperty
	a_invalid_code: assert property (p_invalid_code)
		else $error("invalid command not coded as 10");

	property p_unused_zero;
		sb0_r[3] == 1'b0 && sb1_r[6] == 1'b0 && sb1_r[3] == 1'b0 &&
			sb2_r[7] == 1'b0 && sb2_r[3:2] == 2'b00;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused status bit is set");

	property p_wp_flag;
		executing && is_write_cmd(kind_r) && write_protect_i &&
			cmd_end_i && !soft_reset_i |=> sb1_r[`DRCS_S1_WPROT];
	endproperty
	a_wp_flag: assert property (p_wp_flag)
		else $error("write protect not reported");

	property p_bad_track;
		executing && cmd_end_i && !soft_reset_i && id_track_valid_i &&
			id_track_i == `DRCS_BAD_TRACK && internal_track_i != id_track_i
			|=> sb2_r[`DRCS_S2_BAD] && sb2_r[`DRCS_S2_TRK];
	endproperty
	a_bad_track: assert property (p_bad_track)
		else $error("bad track mismatch not reported");

	property p_crc_data;
		sb2_r[`DRCS_S2_CRC] |-> sb1_r[`DRCS_S1_CRC];
	endproperty
	a_crc_data: assert property (p_crc_data)
		else $error("data field CRC without general CRC flag");

	property p_hold;
		state_r == DRCS_RESULT && !soft_reset_i |=>
			$stable(sb0_r) && $stable(sb1_r) && $stable(sb2_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("status bytes changed during result phase");

	property p_seek_pend;
		ending && is_seek_kind && !soft_reset_i |=> seek_pend_r &&
			state_r == DRCS_IDLE && !request_for_master_o;
	endproperty
	a_seek_pend: assert property (p_seek_pend)
		else $error("seek end not recorded");

	c_full_read: cover property (state_r == DRCS_RESULT && result_rd_i &&
		res_idx_r == `DRCS_BYTE2);
	c_sense_se: cover property (ending && kind_r == DRCS_CMD_SENSE_INT &&
		seek_pend_r);
	c_recal_fault: cover property (recal_fault && ending);
	c_am_timeout: cover property (am_timeout);
endmodule
`default_nettype wire

// >>> drcs_host_model.sv
// Host model that reads result bytes through the data port.
`timescale 1ns/1ps
`default_nettype none

module drcs_host_model (
	input wire logic sys_clk_i,
	input wire logic master_req_i,
	input wire logic dir_i,
	input wire logic [7:0] data_i,
	output logic rd_o
);
	int gap = 0;
	initial rd_o = 1'b0;

	// Stray reads skip the flag wait, to probe refused reads
	task automatic get(output logic [7:0] d, input bit stray);
		int n;
		n = 0;
		repeat (gap) @(negedge sys_clk_i);
		while (!stray && !((master_req_i & dir_i) === 1'b1) && n < 40) begin
			@(negedge sys_clk_i);
			n++;
		end
		d = data_i;
		rd_o = 1'b1;
		@(negedge sys_clk_i);
		rd_o = 1'b0;
		// One low edge between reads keeps each strobe distinct
		@(negedge sys_clk_i);
	endtask
endmodule
`default_nettype wire

// >>> drcs_result_status_tb.sv
// Self-checking bench for the result status block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end

module drcs_result_status_tb;
	import drcs_pkg::*;
	logic sys_clk_i = 0, reset_n_i = 0, soft_reset_i = 0, ccr_wr_i = 0;
	logic legacy_mode_i = 0, density_wr_i = 0, density_val_i = 0;
	logic cmd_start_i = 0, head_i = 1, cmd_end_i = 0, invalid_cmd_i = 0;
	logic poll_abort_i = 0, id_mark_found_i = 0, step_pulse_i = 0;
	logic track_zero_in_i = 0, outward_past_zero_i = 0, result_rd_i;
	logic [7:0] ccr_wdata_i = 0, id_track_i = 8'h05, internal_track_i = 8'h03;
	logic [1:0] drive_number_i = 2'h2;
	logic [13:0] ev = 0;
	drcs_cmd_t cmd_kind_i = DRCS_CMD_OTHER;
	wire logic sector_beyond_i, terminal_count_missing_i, id_crc_err_i;
	wire logic data_crc_err_i, service_late_i, sector_not_found_i;
	wire logic id_unreadable_i, sequence_wrong_i, write_protect_i;
	wire logic index_pulse_in_i, data_mark_absent_i, deleted_mark_seen_i;
	wire logic normal_mark_seen_i, id_track_valid_i;
	logic [7:0] result_data_o, rate_status_o, d;
	logic request_for_master_o, transfer_direction_o, precomp_disable_o;
	logic density_select_out_o;
	int checked = 0, bad_count = 0;

	assign {id_track_valid_i, normal_mark_seen_i, deleted_mark_seen_i,
		data_mark_absent_i, index_pulse_in_i, write_protect_i,
		sequence_wrong_i, id_unreadable_i, sector_not_found_i,
		service_late_i, data_crc_err_i, id_crc_err_i,
		terminal_count_missing_i, sector_beyond_i} = ev;

	always #10 sys_clk_i = ~sys_clk_i;

	drcs_result_status uut (.sys_clk_i, .reset_n_i, .soft_reset_i,
		.ccr_wr_i, .ccr_wdata_i, .legacy_mode_i, .density_wr_i,
		.density_val_i, .cmd_start_i, .cmd_kind_i, .head_i, .drive_number_i,
		.cmd_end_i, .invalid_cmd_i, .poll_abort_i, .sector_beyond_i,
		.terminal_count_missing_i, .id_crc_err_i, .data_crc_err_i,
		.service_late_i, .sector_not_found_i, .id_unreadable_i,
		.sequence_wrong_i, .write_protect_i, .index_pulse_in_i,
		.id_mark_found_i, .data_mark_absent_i, .deleted_mark_seen_i,
		.normal_mark_seen_i, .id_track_valid_i, .id_track_i,
		.internal_track_i, .step_pulse_i, .track_zero_in_i,
		.outward_past_zero_i, .result_rd_i, .result_data_o,
		.request_for_master_o, .transfer_direction_o, .precomp_disable_o,
		.rate_status_o, .density_select_out_o);

	drcs_host_model host (.sys_clk_i, .master_req_i(request_for_master_o),
		.dir_i(transfer_direction_o), .data_i(result_data_o),
		.rd_o(result_rd_i));

	// ------------------------------------------------------------------
	// Command and result helpers
	// ------------------------------------------------------------------
	task automatic tick(int n = 1);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// Events pulse twice with a gap, the second in the end cycle
	task automatic cmd(drcs_cmd_t k, logic [13:0] e, int steps = 0);
		cmd_kind_i = k;
		cmd_start_i = 1;
		tick();
		cmd_start_i = 0;
		repeat (steps) begin
			step_pulse_i = 1;
			tick();
			step_pulse_i = 0;
			tick();
		end
		ev = e;
		tick();
		ev = 0;
		tick();
		ev = e;
		cmd_end_i = 1;
		tick();
		ev = 0;
		cmd_end_i = 0;
	endtask

	// Events stay high while reading: bytes must not move
	task automatic res(logic [7:0] b0, b1, b2, int n);
		logic [7:0] x[3];
		x = '{b0, b1, b2};
		`CHK(transfer_direction_o, 1'b1)
		ev = '1;
		for (int i = 0; i < n; i++) begin
			host.get(d, 0);
			`CHK(d, x[i])
		end
		ev = 0;
		host.get(d, 1);
		`CHK({request_for_master_o, transfer_direction_o, result_data_o},
			{2'b00, x[n-1]})
	endtask

	task automatic dc(drcs_cmd_t k, int b, logic [7:0] s1, s2);
		cmd(k, 14'(1 << b));
		res({((s1 | s2) != 0) ? 2'h1 : 2'h0, 6'h06}, s1, s2, 3);
	endtask

	task automatic sense(logic [7:0] s0);
		cmd(DRCS_CMD_SENSE_INT, 0);
		res(s0, 0, 0, 1);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		bad_count++;
		conclude();
	end

	initial begin
		tick(8);
		`CHK({density_select_out_o, request_for_master_o}, 2'b10)
		reset_n_i = 1;
		legacy_mode_i = 1;
		ccr_wdata_i = 8'h04;
		ccr_wr_i = 1;
		tick();
		ccr_wr_i = 0;
		density_wr_i = 1;
		tick();
		density_wr_i = 0;
		tick();
		`CHK({precomp_disable_o, rate_status_o}, 9'h104)
		`CHK(density_select_out_o, 1'b0)
		cmd(DRCS_CMD_READ, 14'h10);
		soft_reset_i = 1;
		legacy_mode_i = 0;
		tick();
		soft_reset_i = 0;
		tick();
		`CHK({request_for_master_o, precomp_disable_o}, 2'b01)
		`CHK({density_select_out_o, rate_status_o}, 9'h000)
		$display("test config done");
		dc(DRCS_CMD_READ, 14, 8'h00, 8'h00);
		dc(DRCS_CMD_READ, 0, 8'h80, 8'h00);
		dc(DRCS_CMD_WRITE, 1, 8'h80, 8'h00);
		dc(DRCS_CMD_READ, 2, 8'h20, 8'h00);
		dc(DRCS_CMD_READ, 3, 8'h20, 8'h20);
		host.gap = 3;
		dc(DRCS_CMD_WRITE, 4, 8'h10, 8'h00);
		host.gap = 0;
		dc(DRCS_CMD_READ_DEL, 5, 8'h04, 8'h00);
		dc(DRCS_CMD_READ_ID, 6, 8'h04, 8'h00);
		dc(DRCS_CMD_READ_TRACK, 7, 8'h04, 8'h00);
		dc(DRCS_CMD_WRITE_DEL, 8, 8'h02, 8'h00);
		dc(DRCS_CMD_FORMAT, 8, 8'h02, 8'h00);
		dc(DRCS_CMD_READ, 9, 8'h01, 8'h00);
		id_mark_found_i = 1;
		dc(DRCS_CMD_READ, 9, 8'h00, 8'h00);
		id_mark_found_i = 0;
		dc(DRCS_CMD_READ, 10, 8'h01, 8'h01);
		dc(DRCS_CMD_READ, 11, 8'h00, 8'h40);
		dc(DRCS_CMD_READ_DEL, 12, 8'h00, 8'h40);
		dc(DRCS_CMD_READ, 13, 8'h00, 8'h10);
		id_track_i = 8'hff;
		dc(DRCS_CMD_READ, 13, 8'h00, 8'h12);
		$display("test data done");
		invalid_cmd_i = 1;
		cmd(DRCS_CMD_OTHER, 0);
		invalid_cmd_i = 0;
		res(8'h86, 0, 0, 1);
		poll_abort_i = 1;
		head_i = 0;
		drive_number_i = 2'h1;
		cmd(DRCS_CMD_READ, 0);
		poll_abort_i = 0;
		head_i = 1;
		drive_number_i = 2'h2;
		res(8'hc1, 0, 0, 3);
		$display("test codes done");
		cmd(DRCS_CMD_SEEK, 0);
		`CHK(request_for_master_o, 1'b0)
		sense(8'h26);
		cmd(DRCS_CMD_RECAL, 0, 80);
		sense(8'h76);
		cmd(DRCS_CMD_RECAL, 0, 79);
		sense(8'h26);
		track_zero_in_i = 1;
		cmd(DRCS_CMD_RECAL, 0, 80);
		track_zero_in_i = 0;
		sense(8'h26);
		outward_past_zero_i = 1;
		cmd(DRCS_CMD_REL_SEEK, 0);
		outward_past_zero_i = 0;
		sense(8'h76);
		$display("test seek done");
		conclude();
	end
endmodule
`default_nettype wire
